// >>> hdl/cvdstg_pkg.sv
package cvdstg_pkg;
    // register indices on the plain byte port
    localparam logic [3:0] ADDR_PRE = 4'h0;
    localparam logic [3:0] ADDR_ACQ = 4'h1;
    localparam logic [3:0] ADDR_GRD = 4'h2;
    localparam logic [3:0] ADDR_CAP = 4'h3;
    localparam logic [3:0] ADDR_RES0H = 4'h4;
    localparam logic [3:0] ADDR_RES0L = 4'h5;
    localparam logic [3:0] ADDR_RES1H = 4'h6;
    localparam logic [3:0] ADDR_RES1L = 4'h7;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    // field positions
    localparam int GRD_B_OE_BIT = 7;
    localparam int GRD_A_OE_BIT = 6;
    localparam int GRD_POL_BIT = 5;
    localparam int CTRL_DS_BIT = 0;
    localparam int CTRL_IP_BIT = 1;
    localparam int CTRL_JUST_BIT = 2;
    localparam int CTRL_RC_BIT = 3;
    localparam int CTRL_ON_BIT = 4;
    localparam int CTRL_GO_BIT = 5;
    localparam int CTRL_SECOND_BIT = 6;
    // reset values
    localparam logic [6:0] TIME_RESET = 7'h00;
    localparam logic [2:0] GRD_RESET = 3'h0;
    localparam logic [3:0] CAP_RESET = 4'h0;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // instruction cycle is four system clocks
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    typedef enum {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} cvdstg_state_t;

    // bus request grouped as one carrier
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic wrEn;
        logic rdEn;
    } cvdstg_bus_t;

    // analog front end controls grouped
    typedef struct packed {
        logic guardAOut;
        logic guardAOe;
        logic guardBOut;
        logic guardBOe;
        logic [3:0] capSel;
    } cvdstg_front_t;
endpackage

// >>> hdl/cvdstg_top.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - nonzero pre-charge value N holds pre-charge for exactly N timing ticks.
// - zero pre-charge value skips the pre-charge stage entirely.
// - nonzero acquisition value N holds acquisition for exactly N timing ticks.
// - zero acquisition value omits the acquisition stage.
// - with RC clock selected, both timers count RC ticks instead.
// - guard B enable routes guard drive to pin B; clear means undriven.
// - guard A enable routes guard drive to pin A; clear means undriven.
// - polarity bit sets the level both guards start pre-charge with.
// - double sample plus invert flips polarity for second conversion only.
// - enabled guard outputs are driven while converter-on stays set.
// - guard A toggles when acquisition starts; guard B keeps level.
// - four-bit capacitor code selects 2 pF per count, zero disconnects.
// - left justified puts result bits 9..2 in the high byte.
// - left justified puts bits 1..0 in low byte bits 7..6.
// - right justified puts bits 9..8 in high byte bits 1..0.
// - right justified load forces upper six high-byte bits to zero.
// - left justified load forces lower six low-byte bits to zero.
// - right justified puts result bits 7..0 in the low byte.
// - double sample starts second sequence at once, busy stays set.
module cvdstg_top
    import cvdstg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // timing source from the dedicated rc clock, one pulse per period
    input wire logic rcClockTick,
    // successive approximation core
    input wire logic convDone,
    input wire logic [9:0] convData,
    output logic convStart,
    // guard pins and sample capacitor
    output logic guardPinAOut,
    output logic guardPinAOe,
    output logic guardPinBOut,
    output logic guardPinBOe,
    output logic [3:0] extraCapSelect,
    // sequence status
    output logic convBusy,
    output logic [1:0] stageStatus
);

    cvdstg_bus_t bus;
    cvdstg_front_t frontNext;
    cvdstg_state_t state_reg;
    cvdstg_state_t state_next;
    logic [6:0] preTime_reg;
    logic [6:0] acqTime_reg;
    logic [2:0] guard_reg;
    logic [3:0] cap_reg;
    logic [4:0] ctrl_reg;
    logic [7:0] res0High_reg;
    logic [7:0] res0Low_reg;
    logic [7:0] res1High_reg;
    logic [7:0] res1Low_reg;
    logic [1:0] instrDiv_reg;
    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic second_reg;
    logic passNext;
    logic timeTick;
    logic polEff;
    logic goReq;
    logic convOn;
    logic seqEnd;
    logic [7:0] rdMux;
    logic [7:0] loadHigh;
    logic [7:0] loadLow;

    assign bus = '{addr: regAddr, wrData: regWrData, wrEn: regWrEn, rdEn: regRdEn};
    // a go write that also sets the on bit must not be cut off by the stale bit
    assign convOn = ctrl_reg[CTRL_ON_BIT] || goReq;

    // a write is decoded in several places, so keep it in one function
    function automatic logic wrHit(input cvdstg_bus_t b, input logic [3:0] a);
        wrHit = b.wrEn && (b.addr == a);
    endfunction

    // control registers, all cleared by reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            preTime_reg <= TIME_RESET;
            acqTime_reg <= TIME_RESET;
            guard_reg <= GRD_RESET;
            cap_reg <= CAP_RESET;
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            if (wrHit(bus, ADDR_PRE))
                preTime_reg <= bus.wrData[6:0];
            if (wrHit(bus, ADDR_ACQ))
                acqTime_reg <= bus.wrData[6:0];
            if (wrHit(bus, ADDR_GRD))
                guard_reg <= bus.wrData[GRD_B_OE_BIT:GRD_POL_BIT];
            if (wrHit(bus, ADDR_CAP))
                cap_reg <= bus.wrData[3:0];
            if (wrHit(bus, ADDR_CTRL))
                ctrl_reg <= bus.wrData[CTRL_ON_BIT:CTRL_DS_BIT];
        end
    end

    // go is a write of one to the go bit; ignored while busy or off
    assign goReq = wrHit(bus, ADDR_CTRL) && bus.wrData[CTRL_GO_BIT]
        && bus.wrData[CTRL_ON_BIT] && (state_reg == ST_IDLE);

    // instruction cycle divider, free running
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            instrDiv_reg <= 2'h0;
        else
            instrDiv_reg <= instrDiv_reg + 2'h1;
    end

    // timing base: instruction cycles or rc ticks
    assign timeTick = ctrl_reg[CTRL_RC_BIT] ? rcClockTick
        : (instrDiv_reg == INSTR_DIV_LAST);

    // conversion ends a sequence; the last one frees the unit
    assign seqEnd = (state_reg == ST_CONV) && convDone;

    // sequence walker, zero-length stages are skipped
    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (goReq)
                begin
                    if (preTime_reg != 7'h00)
                    begin
                        state_next = ST_PRE;
                        count_next = preTime_reg;
                    end
                    else if (acqTime_reg != 7'h00)
                    begin
                        state_next = ST_ACQ;
                        count_next = acqTime_reg;
                    end
                    else
                        state_next = ST_CONV;
                end
            end
            ST_PRE:
            begin
                if (timeTick)
                begin
                    count_next = count_reg - 7'h01;
                    if (count_reg == 7'h01)
                    begin
                        if (acqTime_reg != 7'h00)
                        begin
                            state_next = ST_ACQ;
                            count_next = acqTime_reg;
                        end
                        else
                            state_next = ST_CONV;
                    end
                end
            end
            ST_ACQ:
            begin
                if (timeTick)
                begin
                    count_next = count_reg - 7'h01;
                    if (count_reg == 7'h01)
                        state_next = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (convDone)
                begin
                    // second pass restarts straight away, busy kept high
                    if (ctrl_reg[CTRL_DS_BIT] && !second_reg)
                    begin
                        if (preTime_reg != 7'h00)
                        begin
                            state_next = ST_PRE;
                            count_next = preTime_reg;
                        end
                        else if (acqTime_reg != 7'h00)
                        begin
                            state_next = ST_ACQ;
                            count_next = acqTime_reg;
                        end
                        else
                            state_next = ST_CONV;
                    end
                    else
                        state_next = ST_IDLE;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
        // turning the converter off aborts any sequence
        if (!convOn)
            state_next = ST_IDLE;
    end

    // state and counter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 7'h00;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // which pass of a double sample is running
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            second_reg <= 1'b0;
        else if (goReq || !convOn)
            second_reg <= 1'b0;
        else if (seqEnd && ctrl_reg[CTRL_DS_BIT] && !second_reg)
            second_reg <= 1'b1;
        else if (seqEnd)
            second_reg <= 1'b0;
    end

    // conversion start pulse and status flags
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            convStart <= 1'b0;
            convBusy <= 1'b0;
            stageStatus <= 2'h0;
        end
        else
        begin
            convStart <= (state_next == ST_CONV) && (state_reg != ST_CONV || convDone);
            convBusy <= (state_next != ST_IDLE);
            case (state_next)
                ST_PRE: stageStatus <= 2'h1;
                ST_ACQ: stageStatus <= 2'h2;
                ST_CONV: stageStatus <= 2'h3;
                default: stageStatus <= 2'h0;
            endcase
        end
    end

    // pass of the coming cycle, so the flipped level lands with the restart edge
    assign passNext = second_reg ? !seqEnd : (seqEnd && ctrl_reg[CTRL_DS_BIT]);

    // the stored polarity bit itself is never altered
    assign polEff = guard_reg[GRD_POL_BIT - GRD_POL_BIT]
        ^ (passNext && ctrl_reg[CTRL_DS_BIT] && ctrl_reg[CTRL_IP_BIT]);

    // guard levels: start at polarity, A flips from acquisition onward
    always_comb
    begin
        frontNext.guardBOut = polEff;
        if (state_next == ST_ACQ || state_next == ST_CONV)
            frontNext.guardAOut = ~polEff;
        else
            frontNext.guardAOut = polEff;
        frontNext.guardAOe = convOn && guard_reg[GRD_A_OE_BIT - GRD_POL_BIT];
        frontNext.guardBOe = convOn && guard_reg[GRD_B_OE_BIT - GRD_POL_BIT];
        frontNext.capSel = cap_reg;
    end

    // pins only carry a level while enabled; held low otherwise
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            guardPinAOut <= 1'b0;
            guardPinAOe <= 1'b0;
            guardPinBOut <= 1'b0;
            guardPinBOe <= 1'b0;
            extraCapSelect <= CAP_RESET;
        end
        else
        begin
            guardPinAOut <= frontNext.guardAOe & frontNext.guardAOut;
            guardPinAOe <= frontNext.guardAOe;
            guardPinBOut <= frontNext.guardBOe & frontNext.guardBOut;
            guardPinBOe <= frontNext.guardBOe;
            extraCapSelect <= frontNext.capSel;
        end
    end

    // result formatting at load time
    always_comb
    begin
        if (ctrl_reg[CTRL_JUST_BIT])
        begin
            loadHigh = {6'h00, convData[9:8]};
            loadLow = convData[7:0];
        end
        else
        begin
            loadHigh = convData[9:2];
            loadLow = {convData[1:0], 6'h00};
        end
    end

    // results have no reset; a load beats a software write
    always_ff @(posedge clk)
    begin
        if (seqEnd && !second_reg)
        begin
            res0High_reg <= loadHigh;
            res0Low_reg <= loadLow;
        end
        else
        begin
            if (wrHit(bus, ADDR_RES0H))
                res0High_reg <= bus.wrData;
            if (wrHit(bus, ADDR_RES0L))
                res0Low_reg <= bus.wrData;
        end
        if (seqEnd && second_reg)
        begin
            res1High_reg <= loadHigh;
            res1Low_reg <= loadLow;
        end
        else
        begin
            if (wrHit(bus, ADDR_RES1H))
                res1High_reg <= bus.wrData;
            if (wrHit(bus, ADDR_RES1L))
                res1Low_reg <= bus.wrData;
        end
    end

    // read decode; unused bits and unmapped addresses read zero
    always_comb
    begin
        case (bus.addr)
            ADDR_PRE: rdMux = {1'b0, preTime_reg};
            ADDR_ACQ: rdMux = {1'b0, acqTime_reg};
            ADDR_GRD: rdMux = {guard_reg, 5'h00};
            ADDR_CAP: rdMux = {4'h0, cap_reg};
            ADDR_RES0H: rdMux = res0High_reg;
            ADDR_RES0L: rdMux = res0Low_reg;
            ADDR_RES1H: rdMux = res1High_reg;
            ADDR_RES1L: rdMux = res1Low_reg;
            ADDR_CTRL: rdMux = {1'b0, second_reg, convBusy, ctrl_reg};
            default: rdMux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            regRdData <= 8'h00;
        else if (bus.rdEn)
            regRdData <= rdMux;
        else
            regRdData <= 8'h00;
    end

endmodule

`default_nettype wire

// >>> verif/cvdstg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cvdstg_assertions
    import cvdstg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    // time base and core
    input wire logic rcClockTick,
    input wire logic convDone,
    input wire logic [9:0] convData,
    input wire logic convStart,
    // front end and status
    input wire logic guardPinAOut,
    input wire logic guardPinAOe,
    input wire logic guardPinBOut,
    input wire logic guardPinBOe,
    input wire logic [3:0] extraCapSelect,
    input wire logic convBusy,
    input wire logic [1:0] stageStatus
);
    logic [6:0] preReg;
    logic [2:0] grdReg;
    logic [3:0] capReg;
    logic [3:0] ctlReg;
    logic passReg;
    logic [9:0] preCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // shadow of written fields; assumes no writes while a sequence runs
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            preReg <= 7'h00;
            grdReg <= 3'h0;
            capReg <= 4'h0;
            ctlReg <= 4'h0;
        end
        else if (regWrEn)
        begin
            if (regAddr == ADDR_PRE) preReg <= regWrData[6:0];
            if (regAddr == ADDR_GRD) grdReg <= regWrData[7:5];
            if (regAddr == ADDR_CAP) capReg <= regWrData[3:0];
            if (regAddr == ADDR_CTRL) ctlReg <= regWrData[3:0];
        end
    end
    // pass marker: clear on go, flips per finished conversion in double sample
    always_ff @(posedge clk)
    begin
        if (sys_rst || (regWrEn && regAddr == ADDR_CTRL && regWrData[CTRL_GO_BIT]))
            passReg <= 1'b0;
        else if (convDone && ctlReg[0])
            passReg <= ~passReg;
    end
    // length of the current pre-charge stage in clocks
    always_ff @(posedge clk)
    begin
        preCnt <= (stageStatus == 2'h1) ? preCnt + 10'h001 : 10'h000;
    end
    AST_OE_ROUTE: assert property (stageStatus != 2'h0 |->
        guardPinAOe == grdReg[1] && guardPinBOe == grdReg[2])
        else $error("guard enable differs from control");
    AST_START_POL: assert property (stageStatus == 2'h1 && !passReg && guardPinBOe |->
        guardPinBOut == grdReg[0])
        else $error("guard start level wrong");
    AST_SECOND_POL: assert property (stageStatus == 2'h1 && passReg && guardPinBOe |->
        guardPinBOut == (grdReg[0] ^ ctlReg[1]))
        else $error("second pass guard level wrong");
    AST_A_SWITCH: assert property (stageStatus[1] && guardPinAOe && guardPinBOe |->
        guardPinAOut != guardPinBOut)
        else $error("guard A did not switch at acquisition");
    AST_PRE_LEN: assert property ($past(stageStatus) == 2'h1 && stageStatus[1] && !ctlReg[3] |->
        preCnt <= 4 * preReg && preCnt + 3 >= 4 * preReg)
        else $error("pre-charge length wrong");
    AST_PRE_SKIP: assert property ($rose(convBusy) && preReg == 7'h00 |->
        stageStatus != 2'h1)
        else $error("zero pre-charge not skipped");
    AST_CONV_START: assert property ($changed(stageStatus) && stageStatus == 2'h3 |->
        convStart)
        else $error("no start pulse entering conversion");
    AST_DONE_IDLE: assert property (convDone && !(ctlReg[0] && !passReg) |=>
        !convBusy && stageStatus == 2'h0)
        else $error("sequence did not end after last conversion");
    AST_DS_RESTART: assert property (convDone && ctlReg[0] && !passReg |=>
        convBusy ##1 convBusy)
        else $error("busy dropped between double sample passes");
    AST_CAP_SEL: assert property (regWrEn && regAddr == ADDR_CAP |->
        ##2 extraCapSelect == $past(regWrData[3:0], 2))
        else $error("capacitor select not following register");
    AST_CAP_READ: assert property (regRdEn && regAddr == ADDR_CAP |=>
        regRdData == {4'h0, capReg})
        else $error("capacitor register read wrong");
    cover property (stageStatus == 2'h2 && guardPinAOe);
    cover property (convDone && passReg);
    cover property (stageStatus == 2'h1 && ctlReg[3]);
endmodule
bind cvdstg_top cvdstg_assertions u_cvdstg_assertions (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .rcClockTick(rcClockTick), .convDone(convDone), .convData(convData),
    .convStart(convStart), .guardPinAOut(guardPinAOut), .guardPinAOe(guardPinAOe),
    .guardPinBOut(guardPinBOut), .guardPinBOe(guardPinBOe),
    .extraCapSelect(extraCapSelect), .convBusy(convBusy), .stageStatus(stageStatus)
);
`default_nettype wire

// >>> verif/cvdstg_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module cvdstg_front_model
    import cvdstg_pkg::*;
#(
    parameter int DLY = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // conversion handshake
    input wire logic convStart,
    input wire logic [9:0] dataIn,
    output logic convDone,
    output logic [9:0] convData = 10'h000
);
    logic [3:0] waitCnt = 4'h0;
    logic [9:0] seqCnt = 10'h000;
    // answers DLY clocks after start; data scrambles only while no conversion is pending, held while waiting
    always_ff @(posedge clk)
    begin
        convDone <= 1'b0;
        if (sys_rst)
            waitCnt <= 4'h0;
        else if (convStart)
            waitCnt <= DLY[3:0];
        else if (waitCnt == 4'h1)
        begin
            convDone <= 1'b1;
            convData <= dataIn + seqCnt;
            seqCnt <= seqCnt + 10'h001;
            waitCnt <= 4'h0;
        end
        else if (waitCnt != 4'h0)
            waitCnt <= waitCnt - 4'h1;
        else
            convData <= ~convData;
    end
endmodule
`default_nettype wire

// >>> verif/cvdstg_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module cvdstg_top_test
    import cvdstg_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic rcClockTick = 1'b0;
    logic [2:0] rcCnt = 3'h0;
    logic [9:0] dataIn = 10'h000;
    logic [7:0] regRdData;
    logic convDone;
    logic [9:0] convData;
    logic convStart;
    logic guardPinAOut;
    logic guardPinAOe;
    logic guardPinBOut;
    logic guardPinBOe;
    logic [3:0] extraCapSelect;
    logic convBusy;
    logic [1:0] stageStatus;
    logic [15:0] lastRes;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int nConv = 0;
    int i;
    cvdstg_top u_cvdstg_top (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .rcClockTick(rcClockTick), .convDone(convDone), .convData(convData),
        .convStart(convStart), .guardPinAOut(guardPinAOut), .guardPinAOe(guardPinAOe),
        .guardPinBOut(guardPinBOut), .guardPinBOe(guardPinBOe),
        .extraCapSelect(extraCapSelect), .convBusy(convBusy), .stageStatus(stageStatus));
    cvdstg_front_model u_cvdstg_front_model (.clk(clk), .sys_rst(sys_rst),
        .convStart(convStart), .dataIn(dataIn), .convDone(convDone), .convData(convData));
    always #10 clk = ~clk;
    // rc tick every 7 clocks, deliberately out of step with the instruction divider
    always @(posedge clk)
    begin
        rcCnt <= (rcCnt == 3'h6) ? 3'h0 : rcCnt + 3'h1;
        rcClockTick <= (rcCnt == 3'h5);
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        check_count++;
        if (act !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask
    task automatic chkRange(input int v, input int lo, input int hi);
        check_count++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h to %h", $time, v, lo, hi);
        end
    endtask
    // left puts the ten bits at the top of the pair, right at the bottom
    function automatic logic [15:0] fmt(input logic [9:0] d, input logic r);
        return r ? {6'h00, d} : {d, 6'h00};
    endfunction
    // one full sequence, stage lengths counted in clocks, then result readback
    task automatic runSeq(input logic [6:0] pre, input logic [6:0] acq, input logic [7:0] ctl,
        input logic [7:0] grd, input int per, input logic [9:0] d);
        int nPre;
        int nAcq;
        int np;
        int k;
        logic seen;
        logic done;
        logic [15:0] res2;
        nPre = 0;
        nAcq = 0;
        seen = 1'b0;
        done = 1'b0;
        np = ctl[CTRL_DS_BIT] ? 2 : 1;
        dataIn <= d;
        wr(ADDR_PRE, {1'b0, pre});
        wr(ADDR_ACQ, {1'b0, acq});
        wr(ADDR_GRD, grd);
        wr(ADDR_CTRL, ctl | 8'h30);
        // sample before waiting, so the cycle right after the go edge is counted
        for (k = 0; k < 3000 && !done; k++)
        begin
            #1;
            seen = seen | (convBusy === 1'b1);
            done = seen && (convBusy === 1'b0);
            nPre += (stageStatus === 2'h1);
            nAcq += (stageStatus === 2'h2);
            @(posedge clk);
        end
        chkRange(nPre, pre ? np * (per * pre - per + 1) : 0, np * per * pre);
        chkRange(nAcq, acq ? np * (per * acq - per + 1) : 0, np * per * acq);
        lastRes = fmt(d + nConv[9:0], ctl[CTRL_JUST_BIT]);
        rdChk(ADDR_RES0H, lastRes[15:8]);
        rdChk(ADDR_RES0L, lastRes[7:0]);
        if (np == 2)
        begin
            res2 = fmt(d + nConv[9:0] + 10'h001, ctl[CTRL_JUST_BIT]);
            rdChk(ADDR_RES1H, res2[15:8]);
            rdChk(ADDR_RES1L, res2[7:0]);
        end
        nConv += np;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i++)
            rdChk(i[3:0], 8'h00);
        rdChk(ADDR_CTRL, 8'h00);
        wr(4'hF, 8'hFF);
        rdChk(4'hF, 8'h00);
        wr(ADDR_PRE, 8'hFF);
        rdChk(ADDR_PRE, 8'h7F);
        wr(ADDR_GRD, 8'hFF);
        rdChk(ADDR_GRD, 8'hE0);
        wr(ADDR_CAP, 8'hFF);
        rdChk(ADDR_CAP, 8'h0F);
        chk({4'h0, extraCapSelect}, 8'h0F);
        runSeq(7'h02, 7'h01, 8'h00, 8'hE0, 4, 10'h2B6);
        runSeq(7'h00, 7'h00, 8'h04, 8'hC0, 4, 10'h1C5);
        runSeq(7'h03, 7'h02, 8'h08, 8'hE0, 7, 10'h3FF);
        runSeq(7'h7F, 7'h7F, 8'h04, 8'h20, 4, 10'h155);
        runSeq(7'h05, 7'h03, 8'h03, 8'hE0, 4, 10'h0A3);
        runSeq(7'h01, 7'h00, 8'h01, 8'h80, 4, 10'h300);
        // switching the converter off mid pre-charge must release the guards
        wr(ADDR_PRE, 8'h7F);
        wr(ADDR_GRD, 8'hC0);
        wr(ADDR_CTRL, 8'h30);
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk({5'h00, convBusy, guardPinAOe, guardPinBOe}, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk(ADDR_CAP, 8'h00);
        rdChk(ADDR_GRD, 8'h00);
        rdChk(ADDR_RES0H, lastRes[15:8]);
        conclude();
    end
endmodule
`default_nettype wire
